// [dv/tb_dfb_core.sv]
`include "dfb_regs.svh"
`default_nettype none
module tb_dfb_core
	import dfb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// signals and expectations
	// ------------------------------------------------------------
	localparam logic [31:0] ALL      = 32'hFFFFFFFF;
	localparam logic [31:0] START_PH = 32'h00015F90 * `DFB_MDEG_PH;
	logic           clk;
	logic           reset;
	logic           wb_cyc;
	logic           wb_stb;
	logic           wb_we;
	logic [7:0]     wb_adr;
	logic [3:0]     wb_sel;
	logic [31:0]    wb_dat_w;
	logic [31:0]    wb_dat_r;
	logic           wb_ack;
	dfb_panel_trigger_key_pins_t panel_trigger_key_pins;
	logic           rate_panel_trigger_key_tick;
	logic [31:0]    phase_word;
	logic           out_enable;
	logic [15:0]    mod_monitor;
	logic           sync_out;
	logic           burst_active;
	logic           trigger_indicator_green;
	logic           trigger_indicator_red;
	int             n_errors = 0;
	int             samples_checked = 0;
	int             act_cnt = 0;
	int             grn_cnt = 0;
	int             red_cnt = 0;

	dfb_core i_dfb_core (
		.clk                     (clk),
		.reset                   (reset),
		.wb_cyc                  (wb_cyc),
		.wb_stb                  (wb_stb),
		.wb_we                   (wb_we),
		.wb_adr                  (wb_adr),
		.wb_sel                  (wb_sel),
		.wb_dat_w                (wb_dat_w),
		.wb_dat_r                (wb_dat_r),
		.wb_ack                  (wb_ack),
		.panel_trigger_key_pins               (panel_trigger_key_pins),
		.rate_panel_trigger_key_tick          (rate_panel_trigger_key_tick),
		.phase_word              (phase_word),
		.out_enable              (out_enable),
		.mod_monitor             (mod_monitor),
		.sync_out                (sync_out),
		.burst_active            (burst_active),
		.trigger_indicator_green (trigger_indicator_green),
		.trigger_indicator_red   (trigger_indicator_red)
	);

	// 125 MHz clock
	initial clk = 1'b0;
	always #4 clk = ~clk;

	// counts sampled mid-cycle; tasks read them after a rising edge, except t_ext, which takes a0 after a falling one
	always @(negedge clk)
	begin
		act_cnt = act_cnt + int'(burst_active === 1'b1);
		grn_cnt = grn_cnt + int'(trigger_indicator_green === 1'b1);
		red_cnt = red_cnt + int'(trigger_indicator_red === 1'b1);
		if (burst_active === 1'b1)
			chk_word({31'h0, sync_out}, 32'h0);
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	// classic cycle; ack and read data taken at the rising edge, released there
	task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat_w <= dat;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20)
			chk_word({31'h0, wb_ack}, 32'h1);
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb_io

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] d;
		wb_io(1'b1, adr, dat, d);
	endtask : wr

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		wb_io(1'b0, adr, 32'h0, d);
		chk_word(d & m, e);
	endtask : rd_chk

	// one-cycle tick, then stand in the cycle after the taking edge
	task automatic pulse_tick;
		@(posedge clk);
		rate_panel_trigger_key_tick <= 1'b1;
		@(posedge clk);
		rate_panel_trigger_key_tick <= 1'b0;
		@(negedge clk);
	endtask : pulse_tick

	// bounded wait for the burst to finish
	task automatic wait_idle;
		int n;
		n = 0;
		while (burst_active === 1'b1 && n < 5000)
		begin
			@(negedge clk);
			n++;
		end
		chk_word({31'h0, burst_active}, 32'h0);
		@(posedge clk);
	endtask : wait_idle

	// one output phase step, modulator held still across it
	task automatic chk_step(input logic [15:0] m, input logic [31:0] d);
		logic [31:0] p0;
		@(negedge clk);
		p0 = phase_word;
		chk_word({16'h0, mod_monitor}, {16'h0, m});
		@(negedge clk);
		chk_word({16'h0, mod_monitor}, {16'h0, m});
		chk_word(phase_word - p0, d);
	endtask : chk_step

	// one pin-started burst from the given source
	task automatic pin_burst(input logic [31:0] ctrl, input dfb_panel_trigger_key_pins_t pins);
		int g0;
		wr(`DFB_A_CTRL, ctrl);
		g0 = grn_cnt;
		@(posedge clk);
		panel_trigger_key_pins <= pins;
		repeat (6) @(posedge clk);
		panel_trigger_key_pins <= 3'b000;
		wait_idle();
		chk_word(32'(grn_cnt - g0), 32'h1);
	endtask : pin_burst

	task automatic give_verdict;
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rd_chk(`DFB_A_CTRL, ALL, 32'h0);
		rd_chk(`DFB_A_CYCLES, ALL, 32'h1);
		rd_chk(`DFB_A_RATE, ALL, `DFB_RATE_RST);
		rd_chk(8'h30, ALL, 32'h0);
		wr(`DFB_A_START, 32'h0006DDD0);
		rd_chk(`DFB_A_START, ALL, 32'h00015F90);
	endtask : t_regs

	// boundary values just inside and just outside the cycle and phase span ranges, and just below the rate range
	task automatic t_limits;
		wr(`DFB_A_CYCLES, 32'h0);
		rd_chk(`DFB_A_CYCLES, ALL, 32'h1);
		rd_chk(`DFB_A_STATUS, 32'h10, 32'h10);
		wr(`DFB_A_STATUS, 32'h18);
		rd_chk(`DFB_A_STATUS, 32'h18, 32'h0);
		wr(`DFB_A_CYCLES, 32'h7531);
		rd_chk(`DFB_A_CYCLES, ALL, 32'h1);
		wr(`DFB_A_CYCLES, 32'h7530);
		rd_chk(`DFB_A_CYCLES, ALL, 32'h7530);
		wr(`DFB_A_PSPAN, 32'h006DDD00);
		rd_chk(`DFB_A_PSPAN, ALL, 32'h0);
		wr(`DFB_A_PSPAN, 32'h006DDCFF);
		rd_chk(`DFB_A_PSPAN, ALL, 32'h006DDCFF);
		wr(`DFB_A_RATE, 32'h8);
		rd_chk(`DFB_A_RATE, ALL, `DFB_RATE_RST);
	endtask : t_limits

	// carrier near 0.98 MHz: 128 clocks a cycle
	task automatic t_mod_refuse;
		wr(`DFB_A_FREQ_HI, 32'h0200);
		wr(`DFB_A_CTRL, 32'h11);
		rd_chk(`DFB_A_STATUS, 32'hC1, 32'h01);
		wr(`DFB_A_CTRL, 32'h15);
		rd_chk(`DFB_A_STATUS, 32'hC1, 32'h01);
		wr(`DFB_A_CTRL, 32'h01);
		rd_chk(`DFB_A_STATUS, 32'hC1, 32'h40);
		wr(`DFB_A_CTRL, 32'h12);
		rd_chk(`DFB_A_STATUS, 32'hC2, 32'h02);
		wr(`DFB_A_CTRL, 32'h16);
		rd_chk(`DFB_A_STATUS, 32'hC2, 32'h02);
	endtask : t_mod_refuse

	// square modulator at top rate, span 2^40: low half 6250 clocks
	task automatic t_mod;
		int n;
		wr(`DFB_A_SPAN_HI, 32'h0100);
		wr(`DFB_A_RATE, `DFB_RATE_MAX);
		wr(`DFB_A_CTRL, 32'h101);
		rd_chk(`DFB_A_STATUS, 32'hC1, 32'h40);
		chk_step(16'h0000, 32'h01800000);
		n = 0;
		while (mod_monitor !== 16'hFFFF && n < 7000)
		begin
			@(negedge clk);
			n++;
		end
		chk_step(16'hFFFF, 32'h027FFF00);
		wr(`DFB_A_CTRL, 32'h102);
		rd_chk(`DFB_A_STATUS, 32'hC2, 32'h80);
		chk_step(16'hFFFF, 32'h02000000);
	endtask : t_mod

	task automatic t_burst;
		int a0;
		int g0;
		int r0;
		wr(`DFB_A_CYCLES, 32'h3);
		wr(`DFB_A_CTRL, 32'h23);
		rd_chk(`DFB_A_STATUS, 32'hC4, 32'hC0);
		wr(`DFB_A_RATE, 32'h64);
		rd_chk(`DFB_A_RATE, ALL, 32'h0);
		rd_chk(`DFB_A_STATUS, 32'h08, 32'h08);
		a0 = act_cnt;
		g0 = grn_cnt;
		r0 = red_cnt;
		pulse_tick();
		chk_word({31'h0, burst_active}, 32'h1);
		chk_word({31'h0, trigger_indicator_green}, 32'h1);
		@(negedge clk);
		chk_word(phase_word, START_PH);
		chk_word({31'h0, out_enable}, 32'h1);
		repeat (20) @(posedge clk);
		pulse_tick();
		chk_word({31'h0, trigger_indicator_red}, 32'h1);
		wait_idle();
		chk_word(32'(act_cnt - a0), 32'h180);
		chk_word(32'(grn_cnt - g0), 32'h1);
		chk_word(32'(red_cnt - r0), 32'h1);
		repeat (4) @(negedge clk);
		chk_word(phase_word, START_PH);
		chk_word({31'h0, out_enable}, 32'h0);
		// key pin while the rate source is selected stays ignored
		@(posedge clk);
		panel_trigger_key_pins <= 3'b001;
		repeat (8) @(posedge clk);
		panel_trigger_key_pins <= 3'b000;
		chk_word(32'(grn_cnt - g0), 32'h1);
	endtask : t_burst

	// one-cycle burst from the external pin; the tick is not this source
	task automatic t_ext;
		int a0;
		int n;
		wr(`DFB_A_CYCLES, 32'h1);
		wr(`DFB_A_CTRL, 32'h43);
		pulse_tick();
		chk_word({31'h0, burst_active}, 32'h0);
		a0 = act_cnt;
		@(posedge clk);
		panel_trigger_key_pins <= 3'b010;
		n = 0;
		while (burst_active !== 1'b1 && n < 10)
		begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		panel_trigger_key_pins <= 3'b000;
		wait_idle();
		chk_word(32'(act_cnt - a0), 32'h80);
		pin_burst(32'h63, 3'b100);
		pin_burst(32'h03, 3'b001);
		wr(`DFB_A_FREQ_HI, 32'h0300);
		rd_chk(`DFB_A_STATUS, 32'hC4, 32'h04);
	endtask : t_ext

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'hF;
		wb_dat_w = 32'h0;
		panel_trigger_key_pins = 3'b000;
		rate_panel_trigger_key_tick = 1'b0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_limits();
		t_mod_refuse();
		t_mod();
		t_burst();
		t_ext();
		give_verdict();
	end

	// about twice the expected run length, the modulator wait dominates
	initial
	begin
		#120000;
		n_errors++;
		give_verdict();
	end
endmodule : tb_dfb_core
`default_nettype wire

// [rtl/dfb_core.sv]
`include "dfb_regs.svh"
`default_nettype none
module dfb_core
	import dfb_pkg::*;
(
	// system
	input  wire logic            clk,
	input  wire logic            reset,
	// wishbone slave
	input  wire logic            wb_cyc,
	input  wire logic            wb_stb,
	input  wire logic            wb_we,
	input  wire logic [7:0]      wb_adr,
	input  wire logic [3:0]      wb_sel,
	input  wire logic [31:0]     wb_dat_w,
	output logic      [31:0]     wb_dat_r,
	output logic                 wb_ack,
	// triggers
	input  wire dfb_panel_trigger_key_pins_t  panel_trigger_key_pins,
	input  wire logic            rate_panel_trigger_key_tick,
	// synthesis side
	output logic      [31:0]     phase_word,
	output logic                 out_enable,
	output logic      [15:0]     mod_monitor,
	output logic                 sync_out,
	output logic                 burst_active,
	output logic                 trigger_indicator_green,
	output logic                 trigger_indicator_red
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	dfb_ctrl_t      ctrl_reg;
	dfb_bstate_t    state_reg;
	logic [47:0]    freq_reg;
	logic [47:0]    span_reg;
	logic [22:0]    pspan_reg;
	logic [31:0]    rate_reg;
	logic [14:0]    cycles_reg;
	logic [18:0]    start_reg;
	logic           na_reg;
	logic           valerr_reg;
	logic           ack_reg;
	logic [31:0]    rdat_reg;
	logic [39:0]    mod_acc_reg;
	logic [47:0]    rel_reg;
	logic [14:0]    cnt_reg;
	logic [14:0]    lim_reg;
	logic [31:0]    phase_reg;
	logic [15:0]    mon_reg;
	logic           sync_reg;
	logic           oen_reg;
	logic           green_reg;
	logic           red_reg;
	logic [2:0]     s1_reg;
	logic [2:0]     s2_reg;
	logic [2:0]     s3_reg;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	// the ack bit blocks a second take while ack is high
	wire req   = wb_cyc & wb_stb & ~ack_reg;
	wire wr_en = req & wb_we;
	wire rd_en = req & ~wb_we;
	wire [31:0] lane_mask;
	genvar gi;
	for (gi = 0; gi < 4; gi++)
	begin : g_lane
		assign lane_mask[gi*8 +: 8] = {8{wb_sel[gi]}};
	end

	function automatic logic [31:0] merge(input logic [31:0] old);
		return (old & ~lane_mask) | (wb_dat_w & lane_mask);
	endfunction : merge

	wire wr_ctrl = wr_en & (wb_adr == `DFB_A_CTRL);
	wire wr_stat = wr_en & (wb_adr == `DFB_A_STATUS);
	wire wr_flo  = wr_en & (wb_adr == `DFB_A_FREQ_LO);
	wire wr_fhi  = wr_en & (wb_adr == `DFB_A_FREQ_HI);
	wire wr_slo  = wr_en & (wb_adr == `DFB_A_SPAN_LO);
	wire wr_shi  = wr_en & (wb_adr == `DFB_A_SPAN_HI);
	wire wr_psp  = wr_en & (wb_adr == `DFB_A_PSPAN);
	wire wr_rate = wr_en & (wb_adr == `DFB_A_RATE);
	wire wr_cyc  = wr_en & (wb_adr == `DFB_A_CYCLES);
	wire wr_st   = wr_en & (wb_adr == `DFB_A_START);
	wire rd_rate = rd_en & (wb_adr == `DFB_A_RATE);

	// candidate values; phase span, rate and cycle count are checked before they are stored
	wire [31:0] m_ctrl = merge({23'h0, ctrl_reg});
	wire [31:0] m_flo  = merge(freq_reg[31:0]);
	wire [31:0] m_fhi  = merge({16'h0, freq_reg[47:32]});
	wire [31:0] m_slo  = merge(span_reg[31:0]);
	wire [31:0] m_shi  = merge({16'h0, span_reg[47:32]});
	wire [31:0] m_psp  = merge({9'h0, pspan_reg});
	wire [31:0] m_rate = merge(rate_reg);
	wire [31:0] m_cyc  = merge({17'h0, cycles_reg});
	wire [31:0] m_st   = merge({13'h0, start_reg});
	wire req_burst = (ctrl_reg.mode == M_BURST);
	wire psp_ok  = (m_psp <= {9'h0, `DFB_PSPAN_MAX});
	wire rate_ok = (m_rate >= `DFB_RATE_MIN) & (m_rate <= `DFB_RATE_MAX);
	wire cyc_ok  = (m_cyc >= 32'h1) & (m_cyc <= {17'h0, `DFB_CYC_MAX});
	// larger phases fold back into one turn
	wire [31:0] st_mod = m_st % `DFB_DEG360;
	wire val_bad = (wr_psp & ~psp_ok) | (wr_cyc & ~cyc_ok)
		| (wr_rate & ~req_burst & ~rate_ok);

	// ------------------------------------------------------------
	// legality of the requested mode
	// ------------------------------------------------------------
	wire is_ns  = (ctrl_reg.func == F_SINE) | (ctrl_reg.func == F_SQUARE);
	wire is_tr  = (ctrl_reg.func == F_TRI) | (ctrl_reg.func == F_RAMP);
	wire is_arb = (ctrl_reg.func == F_ARB);
	// noise, arbitrary and unused codes cannot be modulated
	wire nomod  = ~(is_ns | is_tr);
	wire [47:0] half_w = {1'b0, span_reg[47:1]};
	wire [48:0] hi_w   = {1'b0, freq_reg} + {1'b0, half_w};
	wire [47:0] fmax_w = is_ns ? `DFB_TW_MAX_SQ : `DFB_TW_MAX_TR;
	wire fm_ok = ~nomod & (half_w < freq_reg) & (hi_w <= {1'b0, fmax_w});
	wire pm_ok = ~nomod;
	wire [47:0] bmax_w  = is_ns ? `DFB_TW_BMAX_SQ : `DFB_TW_BMAX_TR;
	wire [83:0] dur_cap = freq_reg * `DFB_DUR_K;
	wire [83:0] dur_need = {21'h0, cycles_reg, 48'h0};
	wire dur_ok = (dur_need <= dur_cap);
	wire bu_ok  = (is_arb | ((is_ns | is_tr) & (freq_reg <= bmax_w))) & dur_ok;
	wire fm_ref = (ctrl_reg.mode == M_FM) & ~fm_ok;
	wire pm_ref = (ctrl_reg.mode == M_PM) & ~pm_ok;
	wire bu_ref = req_burst & ~bu_ok;
	// a refused mode falls back to a plain carrier
	wire dfb_mode_t mode_eff = (fm_ref | pm_ref | bu_ref) ? M_CW : ctrl_reg.mode;
	wire in_fm    = (mode_eff == M_FM);
	wire in_pm    = (mode_eff == M_PM);
	wire in_burst = (mode_eff == M_BURST);

	// ------------------------------------------------------------
	// register write port
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ctrl_reg   <= dfb_ctrl_t'(`DFB_CTRL_RST);
			freq_reg   <= 48'h0;
			span_reg   <= 48'h0;
			pspan_reg  <= 23'h0;
			rate_reg   <= `DFB_RATE_RST;
			cycles_reg <= `DFB_CYCLES_RST;
			start_reg  <= 19'h0;
		end
		else
		begin
			if (wr_ctrl) ctrl_reg <= dfb_ctrl_t'(m_ctrl[8:0]);
			if (wr_flo) freq_reg[31:0] <= m_flo;
			if (wr_fhi) freq_reg[47:32] <= m_fhi[15:0];
			if (wr_slo) span_reg[31:0] <= m_slo;
			if (wr_shi) span_reg[47:32] <= m_shi[15:0];
			if (wr_psp & psp_ok) pspan_reg <= m_psp[22:0];
			// burst mode has no rate to set
			if (wr_rate & ~req_burst & rate_ok) rate_reg <= m_rate;
			if (wr_cyc & cyc_ok) cycles_reg <= m_cyc[14:0];
			if (wr_st) start_reg <= st_mod[18:0];
		end
	end

	// sticky flags: a new event beats a clear in the same cycle
	wire na_ev = req_burst & (wr_rate | rd_rate);
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			na_reg     <= 1'b0;
			valerr_reg <= 1'b0;
		end
		else
		begin
			na_reg     <= na_ev | (na_reg & ~(wr_stat & m_ctrl[`DFB_ST_NA] & wb_sel[0]));
			valerr_reg <= val_bad | (valerr_reg & ~(wr_stat & wb_dat_w[`DFB_ST_VALERR]
				& wb_sel[0]));
		end
	end

	// ------------------------------------------------------------
	// read mux and ack, one wait-state registered answer
	// ------------------------------------------------------------
	wire [31:0] status_w = {24'h0, mode_eff, state_reg == B_RUN, valerr_reg, na_reg,
		bu_ref, pm_ref, fm_ref};
	wire [31:0] rd_mux =
		(wb_adr == `DFB_A_CTRL)    ? {23'h0, ctrl_reg} :
		(wb_adr == `DFB_A_STATUS)  ? status_w :
		(wb_adr == `DFB_A_FREQ_LO) ? freq_reg[31:0] :
		(wb_adr == `DFB_A_FREQ_HI) ? {16'h0, freq_reg[47:32]} :
		(wb_adr == `DFB_A_SPAN_LO) ? span_reg[31:0] :
		(wb_adr == `DFB_A_SPAN_HI) ? {16'h0, span_reg[47:32]} :
		(wb_adr == `DFB_A_PSPAN)   ? {9'h0, pspan_reg} :
		(wb_adr == `DFB_A_RATE)    ? (req_burst ? 32'h0 : rate_reg) :
		(wb_adr == `DFB_A_CYCLES)  ? {17'h0, cycles_reg} :
		(wb_adr == `DFB_A_START)   ? {13'h0, start_reg} : 32'h0;
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0;
		end
		else
		begin
			ack_reg  <= req;
			rdat_reg <= rd_en ? rd_mux : 32'h0;
		end
	end
	assign wb_ack   = ack_reg;
	assign wb_dat_r = rdat_reg;

	// ------------------------------------------------------------
	// modulation generator
	// ------------------------------------------------------------
	wire [15:0] mp   = mod_acc_reg[39:24];
	wire [15:0] tri_w = mp[15] ? ~{mp[14:0], 1'b0} : {mp[14:0], 1'b0};
	wire [15:0] mval = (ctrl_reg.wave == W_SQUARE) ? {16{mp[15]}} :
		(ctrl_reg.wave == W_TRI) ? tri_w : mp;
	// fm: zero code gives the lowest frequency
	wire [63:0] fm_prod = span_reg * mval;
	wire [47:0] inst_tw = freq_reg - half_w + fm_prod[63:16];
	// pm: deviation centred on zero, carrier untouched
	wire [38:0] pm_prod = pspan_reg * mval;
	wire signed [23:0] pm_dev = $signed({1'b0, pm_prod[38:16]})
		- $signed({2'b0, pspan_reg[22:1]});
	wire signed [40:0] pm_ph = pm_dev * $signed({1'b0, `DFB_MDEG_PH});
	wire [31:0] pm_off = in_pm ? pm_ph[31:0] : 32'h0;
	// arbitrary bursts always begin at their first point
	wire [34:0] st_prod = start_reg * `DFB_MDEG_PH;
	wire [31:0] st_off  = (in_burst & ~is_arb) ? st_prod[31:0] : 32'h0;

	always_ff @(posedge clk)
	begin
		if (reset) mod_acc_reg <= 40'h0;
		else if (in_fm | in_pm) mod_acc_reg <= mod_acc_reg + {8'h0, rate_reg};
		else mod_acc_reg <= 40'h0;
	end

	// ------------------------------------------------------------
	// trigger inputs
	// ------------------------------------------------------------
	// s1 is read only by s2; edges are taken from s2 and s3
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s1_reg <= 3'h0;
			s2_reg <= 3'h0;
			s3_reg <= 3'h0;
		end
		else
		begin
			s1_reg <= panel_trigger_key_pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	wire [2:0] rise = s2_reg & ~s3_reg;
	wire panel_trigger_key_ev = (ctrl_reg.tsrc == T_KEY)  ? rise[0] :
		(ctrl_reg.tsrc == T_EXT)  ? rise[1] :
		(ctrl_reg.tsrc == T_LINE) ? rise[2] : rate_panel_trigger_key_tick;
	wire running = (state_reg == B_RUN);
	wire accept  = in_burst & ~running & panel_trigger_key_ev;
	wire panel_trigger_key_err = in_burst & running & panel_trigger_key_ev;

	// ------------------------------------------------------------
	// phase accumulator and burst sequencer
	// ------------------------------------------------------------
	wire [47:0] step    = in_fm ? inst_tw : freq_reg;
	wire [48:0] acc_sum = {1'b0, rel_reg} + {1'b0, step};
	wire [14:0] cnt_inc = cnt_reg + 15'h1;
	// each wrap of the relative phase is one full cycle
	wire done = running & acc_sum[48] & (cnt_inc == lim_reg);
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_reg <= B_IDLE;
			rel_reg   <= 48'h0;
			cnt_reg   <= 15'h0;
			lim_reg   <= `DFB_CYCLES_RST;
		end
		else if (!in_burst)
		begin
			state_reg <= B_IDLE;
			rel_reg   <= acc_sum[47:0];
			cnt_reg   <= 15'h0;
		end
		else
		begin
			unique case (state_reg)
				B_IDLE:
				begin
					rel_reg <= 48'h0;
					cnt_reg <= 15'h0;
					if (accept)
					begin
						state_reg <= B_RUN;
						// count is frozen for this burst
						lim_reg   <= cycles_reg;
					end
				end
				B_RUN:
				begin
					// further triggers have no effect here
					rel_reg <= done ? 48'h0 : acc_sum[47:0];
					if (acc_sum[48]) cnt_reg <= cnt_inc;
					if (done) state_reg <= B_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			phase_reg <= 32'h0;
			mon_reg   <= 16'h0;
			sync_reg  <= 1'b0;
			oen_reg   <= 1'b0;
			green_reg <= 1'b0;
			red_reg   <= 1'b0;
		end
		else
		begin
			phase_reg <= rel_reg[47:16] + pm_off + st_off;
			mon_reg   <= (in_fm | in_pm) ? mval : 16'h0;
			sync_reg  <= ~in_burst & ~rel_reg[47];
			oen_reg   <= ~in_burst | running;
			green_reg <= accept;
			red_reg   <= panel_trigger_key_err;
		end
	end
	assign phase_word              = phase_reg;
	assign mod_monitor             = mon_reg;
	assign sync_out                = sync_reg;
	assign out_enable              = oen_reg;
	assign burst_active            = running;
	assign trigger_indicator_green = green_reg;
	assign trigger_indicator_red   = red_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking dfb_cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_fm_refuse;
		(ctrl_reg.mode == M_FM) && nomod |-> mode_eff == M_CW;
	endproperty
	a_fm_refuse: assert property (p_fm_refuse) else $error("fm applied to bad function");
	property p_fm_band;
		in_fm |-> (inst_tw >= freq_reg - half_w) && (inst_tw <= freq_reg + half_w);
	endproperty
	a_fm_band: assert property (p_fm_band) else $error("fm outside span");
	property p_fm_mon;
		in_fm && (mval == 16'h0) |-> (inst_tw == freq_reg - half_w) ##1 mod_monitor == 16'h0;
	endproperty
	a_fm_mon: assert property (p_fm_mon) else $error("fm monitor misaligned");
	property p_fm_range;
		in_fm |-> (half_w < freq_reg) && (hi_w <= {1'b0, fmax_w});
	endproperty
	a_fm_range: assert property (p_fm_range) else $error("fm span out of range");
	property p_pm_refuse;
		(ctrl_reg.mode == M_PM) && nomod |-> !in_pm;
	endproperty
	a_pm_refuse: assert property (p_pm_refuse) else $error("pm applied to bad function");
	property p_pm_span;
		pspan_reg <= `DFB_PSPAN_MAX;
	endproperty
	a_pm_span: assert property (p_pm_span) else $error("pm span too large");
	property p_cycles;
		running |-> (lim_reg >= 15'h1) && (lim_reg <= `DFB_CYC_MAX) && (cnt_reg < lim_reg);
	endproperty
	a_cycles: assert property (p_cycles) else $error("burst count out of range");
	// relative phase restarts at zero, so the first output word is the start offset
	property p_start;
		accept ##1 in_burst |-> rel_reg == 48'h0 ##1 phase_word == $past(st_off);
	endproperty
	a_start: assert property (p_start) else $error("burst not begun at start phase");
	property p_green;
		accept |=> trigger_indicator_green && burst_active;
	endproperty
	a_green: assert property (p_green) else $error("started burst not flagged");
	property p_red;
		panel_trigger_key_err |=> trigger_indicator_red && !trigger_indicator_green;
	endproperty
	a_red: assert property (p_red) else $error("trigger error not flagged");
	property p_reload;
		in_burst && done ##1 in_burst |-> rel_reg == 48'h0 && !burst_active;
	endproperty
	a_reload: assert property (p_reload) else $error("start phase not reloaded");
	property p_sync;
		in_burst [*2] |-> !sync_out;
	endproperty
	a_sync: assert property (p_sync) else $error("sync active in burst");
	property p_blim;
		running && in_burst |-> is_arb || freq_reg <= bmax_w;
	endproperty
	a_blim: assert property (p_blim) else $error("burst carrier too high");

	c_burst: cover property (accept ##[1:1000] done);
	c_err: cover property (panel_trigger_key_err ##1 trigger_indicator_red);
	c_fm: cover property (in_fm [*8]);
endmodule : dfb_core
`default_nettype wire

// [rtl/dfb_pkg.sv]
`default_nettype none
package dfb_pkg;
	// ------------------------------------------------------------
	// modes, functions, trigger sources
	// ------------------------------------------------------------
	typedef enum logic [1:0] {M_CW, M_FM, M_PM, M_BURST} dfb_mode_t;
	typedef enum logic [2:0] {F_SINE, F_SQUARE, F_TRI, F_RAMP, F_NOISE, F_ARB} dfb_func_t;
	typedef enum logic [1:0] {T_KEY, T_RATE, T_EXT, T_LINE} dfb_tsrc_t;
	typedef enum logic [1:0] {W_RAMP, W_TRI, W_SQUARE} dfb_mwave_t;
	typedef enum logic {B_IDLE, B_RUN} dfb_bstate_t;
	// control word, mode in the low bits
	typedef struct packed {
		dfb_mwave_t wave;
		dfb_tsrc_t  tsrc;
		dfb_func_t  func;
		dfb_mode_t  mode;
	} dfb_ctrl_t;
	// trigger pins from outside the clock domain
	typedef struct packed {
		logic line;
		logic ext;
		logic key;
	} dfb_panel_trigger_key_pins_t;
endpackage : dfb_pkg
`default_nettype wire

// [rtl/dfb_regs.svh]
`ifndef DFB_REGS_SVH
`define DFB_REGS_SVH
// ------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define DFB_A_CTRL    8'h00
`define DFB_A_STATUS  8'h04
`define DFB_A_FREQ_LO 8'h08
`define DFB_A_FREQ_HI 8'h0C
`define DFB_A_SPAN_LO 8'h10
`define DFB_A_SPAN_HI 8'h14
`define DFB_A_PSPAN   8'h18
`define DFB_A_RATE    8'h1C
`define DFB_A_CYCLES  8'h20
`define DFB_A_START   8'h24
// ------------------------------------------------------------
// status bit positions
// ------------------------------------------------------------
`define DFB_ST_FM_REF 0
`define DFB_ST_PM_REF 1
`define DFB_ST_BU_REF 2
`define DFB_ST_NA     3
`define DFB_ST_VALERR 4
`define DFB_ST_ACTIVE 5
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DFB_CTRL_RST   9'h000
`define DFB_CYCLES_RST 15'h0001
`define DFB_RATE_RST   32'h00000009
// ------------------------------------------------------------
// limits; tuning words are f * 2^48 / 125 MHz
// ------------------------------------------------------------
`define DFB_TW_MAX_SQ  48'h3DD97F62B6AE
`define DFB_TW_MAX_TR  48'h00346DC5D638
`define DFB_TW_BMAX_SQ 48'h020C49BA5E35
`define DFB_TW_BMAX_TR 48'h00346DC5D638
// 500 s times 125 MHz, burst length cap
`define DFB_DUR_K      36'hE8D4A5100
// modulation rate words are f * 2^40 / 125 MHz
`define DFB_RATE_MIN   32'h00000009
`define DFB_RATE_MAX   32'h053E2D62
`define DFB_PSPAN_MAX  23'h6DDCFF
`define DFB_CYC_MAX    15'h7530
`define DFB_DEG360     32'h00057E40
// one millidegree in 2^32 phase units
`define DFB_MDEG_PH    16'h2E9A
`endif
